// ---- bench/dcs_ctrl_model.sv ----
// Memory controller model: clock pairs, commands and write data.
// Assumes the bench resolves the shared bus from m_oe and data_io_oe.
`timescale 1ns/100ps
module dcs_ctrl_model #(
    parameter int AW = 4
) (
    // Strap
    input  wire logic     single,
    // Clock pairs
    output logic          k,
    output logic          k_n,
    output logic          c,
    output logic          c_n,
    // Commands, one load strobe for this bank
    output logic          load_n,
    output logic          rw,
    output logic [AW-1:0] addr_in,
    output logic [1:0]    burst_low_bits,
    // Write data
    output logic [3:0]    byte_write_n,
    output logic [35:0]   m_data,
    output logic          m_oe
);
    logic c_d;
    int   busy = 0;

    assign k_n = ~k;
    assign c   = single | c_d;
    assign c_n = single | ~c_d;

    initial begin
        {load_n, rw, addr_in, burst_low_bits} = '1;
        byte_write_n = 4'hf;
        m_data = 36'h0;
        m_oe = 1'b0;
        c_d = 1'b0;
        k = 1'b0;
        forever #80 k = ~k;
    end

    // Output clocks lag the main pair by a quarter period
    always @(k) c_d <= #40 k;

    ////////////////////////////////////////////////////////////////////////
    task automatic issue(input logic ld, input logic r,
                         input logic [AW-1:0] a, input logic [1:0] s);
        @(posedge k_n);
        load_n <= ld;
        rw <= r;
        addr_in <= a;
        burst_low_bits <= s;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [1:0] s,
                      input logic [35:0] d [4], input logic [3:0] bw [4]);
        issue(1'b0, 1'b0, a, s);
        busy++;
        fork
            begin
                for (int i = 0; i < 4; i++) begin
                    if (i % 2 == 0) @(posedge k_n);
                    else @(posedge k);
                    // Change a quarter period off the edge so each word
                    // stands clear of both neighbouring capture edges
                    #40;
                    m_data <= d[i];
                    byte_write_n <= bw[i];
                    m_oe <= 1'b1;
                end
                @(posedge k_n);
                #40;
                busy--;
                // Released line shows the inverse, never the last word
                if (busy == 0) begin
                    m_oe <= 1'b0;
                    m_data <= ~m_data;
                end
            end
        join_none
    endtask
endmodule // dcs_ctrl_model

// ---- bench/dcs_port_checker.sv ----
// Pin-level assertions for the SRAM port, bound into dcs_sram_port.
// Assumes each clock phase spans several ref_clk cycles.
`timescale 1ns/100ps
module dcs_port_checker #(
    parameter int DATA_W = 36
) (
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              rst,
    // Pins
    input wire logic              k,
    input wire logic              k_n,
    input wire logic              c,
    input wire logic              c_n,
    input wire logic              load_n,
    input wire logic              rw,
    input wire logic [DATA_W-1:0] data_io_out,
    input wire logic              data_io_oe,
    input wire logic [1:0]        echo_pair
);
    logic [5:0] s1, s2, s3;
    logic [7:0] rd_age, oe_run, oclk_age;
    logic [3:0] rel_cnt;
    wire  [5:0] rise    = s2 & ~s3;
    wire        single  = s3[3] & s3[2];
    wire        rd_take = rise[5] & ~s2[1] & s2[0];
    wire        oclk_r  = single ? |rise[5:4] : |rise[3:2];

    // Same two-flop view of the pins as the port has
    always_ff @(posedge ref_clk) begin
        s1 <= {k, k_n, c, c_n, load_n, rw};
        s2 <= s1;
        s3 <= s2;
    end

    // Saturating ages; the strap is only trusted once rel_cnt is full
    always_ff @(posedge ref_clk) begin
        rel_cnt <= rst ? 4'h0 : rel_cnt + {3'h0, rel_cnt != 4'hf};
        rd_age <= rst ? 8'hff : rd_take ? 8'h00
                  : rd_age + {7'h0, rd_age != 8'hff};
        oe_run <= (rst || !data_io_oe) ? 8'h00
                  : oe_run + {7'h0, oe_run != 8'hff};
        oclk_age <= (rst || oclk_r) ? 8'h00
                    : oclk_age + {7'h0, oclk_age != 8'hff};
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence rd_cmd_s;
        rd_take && !data_io_oe;
    endsequence
    sequence first_word_s;
        !data_io_oe [*6] ##[1:60] data_io_oe;
    endsequence

    rd_launch_a: assert property (rd_cmd_s |=> first_word_s)
        else $error("read did not launch its first word in time");
    burst_len_a: assert property ($fell(data_io_oe) |-> oe_run >= 8'd31)
        else $error("data bus released before four words stood");
    oe_bound_a: assert property (data_io_oe |-> oe_run < 8'd200)
        else $error("data bus never released");
    desel_quiet_a: assert property (rise[5] && s2[1] && !data_io_oe
        && rd_age > 8'd40 |=> !data_io_oe [*8])
        else $error("bus driven after a deselect");
    wr_quiet_a: assert property (rise[5] && !s2[1] && !s2[0]
        && !data_io_oe && rd_age > 8'd40 |=> !data_io_oe [*8])
        else $error("bus driven after a write command");
    echo_follow_a: assert property (((single ? rise[5] : rise[3])
        && rel_cnt == 4'hf) |-> ##[0:2] echo_pair == 2'b10)
        else $error("echo pair does not follow the timing clock");
    word_stand_a: assert property ($changed(data_io_out) && data_io_oe
        |=> $stable(data_io_out) [*4])
        else $error("read word did not stand");
    launch_edge_a: assert property ($changed(data_io_out) && data_io_oe
        |-> oclk_age <= 8'd3)
        else $error("read word launched off an output clock edge");
    oe_edge_a: assert property ($rose(data_io_oe) |-> oclk_age <= 8'd3)
        else $error("bus driven off an output clock edge");
endmodule // dcs_port_checker

bind dcs_sram_port dcs_port_checker #(.DATA_W(DATA_W)) i_dcs_port_checker (
    .ref_clk(ref_clk), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .load_n(load_n), .rw(rw), .data_io_out(data_io_out),
    .data_io_oe(data_io_oe), .echo_pair(echo_pair)
);

// ---- bench/testbench.sv ----
// Self-checking bench for the DDR common-I/O burst-of-four SRAM port.
// Assumes dcs_ctrl_model on the pins and the checker bound by its file.
`timescale 1ns/100ps
`include "dcs_map.svh"
module testbench;
    localparam int AW = 4;
    localparam int DW = `DCS_DATA_W;
    logic          ref_clk, rst, ce, single;
    logic          k, k_n, c, c_n, load_n, rw, m_oe, data_io_oe;
    logic [AW-1:0] addr_in;
    logic [1:0]    burst_low_bits, echo_pair;
    logic [3:0]    byte_write_n;
    logic [DW-1:0] m_data, data_io_in, data_io_out;
    logic [DW-1:0] shadow [64];
    logic [DW-1:0] exp_q [$];
    int            n_mismatch = 0;
    int            samples_checked = 0;
    int            cycles = 0;

    assign data_io_in = (data_io_oe & m_oe) ? {DW{1'bx}} :
                        data_io_oe ? data_io_out : m_data;

    dcs_ctrl_model #(.AW(AW)) i_dcs_ctrl_model (.single(single), .k(k),
        .k_n(k_n), .c(c), .c_n(c_n), .load_n(load_n), .rw(rw),
        .addr_in(addr_in), .burst_low_bits(burst_low_bits),
        .byte_write_n(byte_write_n), .m_data(m_data), .m_oe(m_oe));

    dcs_sram_port #(.DATA_W(DW), .ADDR_W(AW)) i_dcs_sram_port (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .k(k), .k_n(k_n), .c(c),
        .c_n(c_n), .load_n(load_n), .rw(rw), .addr_in(addr_in),
        .burst_low_bits(burst_low_bits), .byte_write_n(byte_write_n),
        .data_io_in(data_io_in), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .echo_pair(echo_pair));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 25000) begin
            n_mismatch++;
            test_done();
        end
    end

    // Takes one word per output clock edge while the bus is driven
    always begin
        @(posedge (single ? k : c) or posedge (single ? k_n : c_n));
        repeat (6) @(posedge ref_clk);
        if (data_io_oe === 1'b1 && exp_q.size() > 0) begin
            check("word", data_io_out, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [DW-1:0] seen,
                         input logic [DW-1:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Deselect cycles carry random junk on the command pins
    task automatic idle(input int n);
        repeat (n) i_dcs_ctrl_model.issue(1'b1, 1'($urandom()),
                                          AW'($urandom()), 2'($urandom()));
    endtask

    task automatic wr(input logic [AW-1:0] loc, input logic [1:0] s,
                      input logic full);
        logic [DW-1:0] d [4];
        logic [3:0]    bw [4];
        logic [AW+1:0] ix;
        for (int i = 0; i < 4; i++) begin
            d[i] = DW'({$urandom(), $urandom()});
            bw[i] = full ? 4'h0 : 4'($urandom());
            ix = {loc, 2'(s + i)};
            for (int l = 0; l < 4; l++) begin
                if (!bw[i][l]) begin
                    shadow[ix][9*l +: 9] = d[i][9*l +: 9];
                end
            end
        end
        i_dcs_ctrl_model.wr(loc, s, d, bw);
    endtask

    task automatic rd(input logic [AW-1:0] loc, input logic [1:0] s);
        i_dcs_ctrl_model.issue(1'b0, 1'b1, loc, s);
        @(posedge k);
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(shadow[{loc, 2'(s + i)}]);
        end
    endtask

    task automatic drain();
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge ref_clk);
        check("words left", DW'(exp_q.size()), '0);
        idle(2);
    endtask

    task automatic run_mode(input string name);
        // Writes every other true rise keep the data phases gapless
        for (int l = 0; l < 4; l++) begin
            wr(AW'(l), 2'(l), 1'b1);
            idle(1);
        end
        idle(2);
        for (int l = 0; l < 4; l++) begin
            rd(AW'(l), 2'(l + 1));
            idle(1);
        end
        drain();
        wr(AW'(1), 2'h2, 1'b0);
        idle(1);
        wr(AW'(2), 2'h3, 1'b0);
        idle(2);
        rd(AW'(1), 2'h0);
        idle(1);
        rd(AW'(2), 2'h1);
        drain();
        $display("test %s done, checks %0d", name, samples_checked);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        single = 1'b0;
        void'($urandom(32'hc17b));
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        // Main clocks run idle long enough for a lock before any access
        repeat (`DCS_LOCK_CYCLES) @(posedge k);
        run_mode("dual clock");
        // The strap must stand before reset is released
        @(posedge ref_clk);
        #1 rst = 1'b1;
        single = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (20) @(posedge ref_clk);
        // Short freeze between main edges, nothing in flight
        @(posedge k);
        repeat (4) @(posedge ref_clk);
        #1 ce = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 ce = 1'b1;
        run_mode("single clock");
        test_done();
    end
endmodule // testbench

// ---- verilog/dcs_map.svh ----
// Constants for the DDR common-I/O burst-of-four SRAM port.
// Assumes it is included by the port design file and by the bench only.
//
// Operation
// - Read taken: load low, select high, true rise
// - Read address captured on that same edge
// - Each read returns exactly four words
// - First read word after next complement main rise
// - Later read words alternate output clock phases
// - Back-to-back reads give gapless output data
// - Output clocks both high: time from main
// - Finish read burst, then deselect at true rise
// - Deselected after read: release data bus
// - Write taken: load low, select low, true rise
// - Write address registered at next true rise
// - Each write stores exactly four words; here only two if the next write is taken at the next true rise
// - First write word captured at next true rise
// - Later write words alternate main clock phases
// - Back-to-back writes accept data every phase; here the next write cuts the earlier burst to two words
// - Load inactive: deselect, ignore unclaimed bus data
// - Enables zero/one gate bits 0-8 and 9-17
// - Enables two/three gate bits 18-26, 27-35
// - Low bits pick start word, rest the location
// - Accepted reads and writes complete before deselect
// - Burst addresses increment modulo four, linearly
// - Clock stop completes pending work, holds outputs; here ce low freezes all state, so pending work waits with the outputs
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

`define DCS_BURST_WORDS   4
`define DCS_BURST_BITS    2
`define DCS_LANE_W        9
`define DCS_DATA_W        36
`define DCS_ADDR_W        17
`define DCS_FIFO_DEPTH    4
`define DCS_OWED_W        4
`define DCS_STRAP_WAIT    2'h3
`define DCS_LOCK_CYCLES   1024

`endif

// ---- verilog/dcs_pkg.sv ----
// Types for the DDR common-I/O burst-of-four SRAM port.
// Assumes no other package; used by qualified names only.
package dcs_pkg;

    typedef enum logic [1:0] {
        DCS_L_IDLE    = 2'b00,
        DCS_L_WAIT_KN = 2'b01,
        DCS_L_WAIT_CN = 2'b10,
        DCS_L_STREAM  = 2'b11
    } dcs_launch_type;

endpackage

// ---- verilog/dcs_sram_port.sv ----
// SRAM core behind a DDR common-I/O pin set, plus its read data FIFO.
// Assumes every pin is asynchronous to ref_clk and toggles slowly enough
// (main clock period of many ref_clk cycles) for edges to be found.
`timescale 1ns/100ps
`include "dcs_map.svh"

////////////////////////////////////////////////////////////////////////////
module dcs_fifo #(
    parameter int WIDTH = `DCS_DATA_W,
    parameter int DEPTH = `DCS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = store[rd_ptr_reg];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= bump(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= bump(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (PW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (PW+1)'(1);
            end
        end
    end
endmodule // dcs_fifo

////////////////////////////////////////////////////////////////////////////
module dcs_sram_port #(
    parameter int DATA_W = `DCS_DATA_W,
    parameter int ADDR_W = `DCS_ADDR_W
) (
    // Clock, reset, freeze
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Main and output clock pairs, as pins
    input  wire logic                 k,
    input  wire logic                 k_n,
    input  wire logic                 c,
    input  wire logic                 c_n,
    // Command pins
    input  wire logic                 load_n,
    input  wire logic                 rw,
    input  wire logic [ADDR_W-1:0]    addr_in,
    input  wire logic [1:0]           burst_low_bits,
    input  wire logic [DATA_W/9-1:0]  byte_write_n,
    // Shared data bus
    input  wire logic [DATA_W-1:0]    data_io_in,
    output logic [DATA_W-1:0]         data_io_out,
    output logic                      data_io_oe,
    // Echo clocks, true then complement
    output logic [1:0]                echo_pair
);
    localparam int LANES = DATA_W / `DCS_LANE_W;
    localparam int FA_W  = ADDR_W + `DCS_BURST_BITS;
    localparam int PIN_W = 6 + ADDR_W + 2 + LANES + DATA_W;
    localparam logic [`DCS_OWED_W-1:0] BURST_CNT =
        `DCS_OWED_W'(`DCS_BURST_WORDS);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge finding
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic [3:0]       clk_prev_reg;
    logic             k_s;
    logic             kn_s;
    logic             c_s;
    logic             cn_s;
    logic             load_n_s;
    logic             rw_s;
    logic [ADDR_W-1:0] addr_s;
    logic [1:0]       start_s;
    logic [LANES-1:0] bw_n_s;
    logic [DATA_W-1:0] din_s;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else if (ce) begin
            pin_s1_reg <= {k, k_n, c, c_n, load_n, rw, addr_in,
                           burst_low_bits, byte_write_n, data_io_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_s, addr_s,
            start_s, bw_n_s, din_s} = pin_s2_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_prev_reg <= '0;
        end else if (ce) begin
            clk_prev_reg <= {k_s, kn_s, c_s, cn_s};
        end
    end

    // Clock stop: with ce low nothing moves; with no main edges no command is taken, but the generator still fills the FIFO
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    assign k_rise  = ce && k_s  && !clk_prev_reg[3];
    assign kn_rise = ce && kn_s && !clk_prev_reg[2];
    assign c_rise  = ce && c_s  && !clk_prev_reg[1];
    assign cn_rise = ce && cn_s && !clk_prev_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Single clock strap, caught once after reset release
    logic [1:0] strap_cnt_reg;
    logic       strap_done_reg;
    logic       single_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_cnt_reg  <= '0;
            strap_done_reg <= 1'b0;
            single_reg     <= 1'b0;
        end else if (ce && !strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == `DCS_STRAP_WAIT) begin
                // Never re-sampled: the mode cannot change later
                single_reg     <= c_s && cn_s;
                strap_done_reg <= 1'b1;
            end
        end
    end

    logic oc_p_edge;
    logic oc_n_edge;
    assign oc_p_edge = single_reg ? k_rise  : c_rise;
    assign oc_n_edge = single_reg ? kn_rise : cn_rise;

    ////////////////////////////////////////////////////////////////////////
    // Commands
    function automatic logic [FA_W-1:0] burst_addr(
        input logic [FA_W-1:0] base,
        input logic [1:0]      idx
    );
        // Linear order, wrapping inside the four-word group
        return {base[FA_W-1:2], base[1:0] + idx};
    endfunction

    logic rd_pend_reg;
    logic rd_cmd;
    logic wr_cmd;
    // Load high at a true rise is a deselect: no command taken
    assign rd_cmd = k_rise && strap_done_reg && !load_n_s && rw_s
                    && !rd_pend_reg;
    assign wr_cmd = k_rise && strap_done_reg && !load_n_s && !rw_s;

    ////////////////////////////////////////////////////////////////////////
    // Write burst capture and memory
    logic [DATA_W-1:0] mem [2**FA_W];
    logic              wr_pend_reg;
    logic [FA_W-1:0]   wr_hold_reg;
    logic [FA_W-1:0]   wr_addr_reg;
    logic              wr_act_reg;
    logic [1:0]        wr_cnt_reg;
    logic              wr_we;
    logic [FA_W-1:0]   wr_word_addr;

    always_comb begin
        wr_we        = 1'b0;
        wr_word_addr = wr_addr_reg;
        // Bus data is taken only at edges owned by an accepted write
        if (k_rise && wr_pend_reg) begin
            wr_we        = 1'b1;
            wr_word_addr = burst_addr(wr_hold_reg, 2'h0);
        end else if (k_rise && wr_act_reg && wr_cnt_reg == 2'h2) begin
            wr_we        = 1'b1;
            wr_word_addr = burst_addr(wr_addr_reg, 2'h2);
        end else if (kn_rise && wr_act_reg && wr_cnt_reg[0]) begin
            wr_we        = 1'b1;
            wr_word_addr = burst_addr(wr_addr_reg, wr_cnt_reg);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_hold_reg <= '0;
            wr_addr_reg <= '0;
            wr_act_reg  <= 1'b0;
            wr_cnt_reg  <= '0;
        end else begin
            if (k_rise) begin
                wr_pend_reg <= wr_cmd;
                if (wr_cmd) begin
                    wr_hold_reg <= {addr_s, start_s};
                end
            end
            if (k_rise && wr_pend_reg) begin
                wr_addr_reg <= wr_hold_reg;
                wr_act_reg  <= 1'b1;
                wr_cnt_reg  <= 2'h1;
            end else if (wr_we) begin
                wr_cnt_reg <= wr_cnt_reg + 2'h1;
                if (wr_cnt_reg == 2'h3) begin
                    wr_act_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_we) begin
            for (int i = 0; i < LANES; i++) begin
                if (!bw_n_s[i]) begin
                    mem[wr_word_addr][i*`DCS_LANE_W +: `DCS_LANE_W]
                        <= din_s[i*`DCS_LANE_W +: `DCS_LANE_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read word generator: fills the FIFO, yields to writes
    logic [FA_W-1:0] rd_pend_addr_reg;
    logic [FA_W-1:0] gen_base_reg;
    logic [1:0]      gen_idx_reg;
    logic [2:0]      gen_cnt_reg;
    logic            fifo_in_ready;
    logic            gen_push;
    logic            gen_free;
    logic            fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic            launch;

    assign gen_push = ce && gen_cnt_reg != 3'h0 && fifo_in_ready && !wr_we;
    assign gen_free = (gen_cnt_reg == 3'h0) ||
                      (gen_push && gen_cnt_reg == 3'h1);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_pend_reg      <= 1'b0;
            rd_pend_addr_reg <= '0;
            gen_base_reg     <= '0;
            gen_idx_reg      <= '0;
            gen_cnt_reg      <= '0;
        end else if (ce) begin
            if (gen_free && rd_pend_reg) begin
                gen_base_reg <= rd_pend_addr_reg;
                gen_idx_reg  <= '0;
                gen_cnt_reg  <= 3'h4;
                rd_pend_reg  <= 1'b0;
            end else if (gen_free && rd_cmd) begin
                gen_base_reg <= {addr_s, start_s};
                gen_idx_reg  <= '0;
                gen_cnt_reg  <= 3'h4;
            end else if (gen_push) begin
                gen_idx_reg <= gen_idx_reg + 2'h1;
                gen_cnt_reg <= gen_cnt_reg - 3'h1;
            end
            if (rd_cmd && !(gen_free && !rd_pend_reg)) begin
                rd_pend_reg      <= 1'b1;
                rd_pend_addr_reg <= {addr_s, start_s};
            end
        end
    end

    dcs_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (`DCS_FIFO_DEPTH)
    ) u_rd_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (gen_push),
        .in_ready  (fifo_in_ready),
        .in_data   (mem[burst_addr(gen_base_reg, gen_idx_reg)]),
        .out_valid (fifo_out_valid),
        .out_ready (launch),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Output launcher
    dcs_pkg::dcs_launch_type lstate_reg;
    logic [`DCS_OWED_W-1:0]  owed_reg;
    logic                    exp_n_reg;
    logic                    want_edge;

    always_comb begin
        want_edge = 1'b0;
        case (lstate_reg)
            dcs_pkg::DCS_L_WAIT_KN: begin
                want_edge = single_reg && kn_rise;
            end
            dcs_pkg::DCS_L_WAIT_CN: begin
                want_edge = oc_n_edge;
            end
            dcs_pkg::DCS_L_STREAM: begin
                want_edge = exp_n_reg ? oc_n_edge : oc_p_edge;
            end
            default: begin
                want_edge = 1'b0;
            end
        endcase
    end

    // A word missing from the FIFO would stall the stream; the generator
    // has many ref_clk cycles per phase, so it stays ahead.
    assign launch = want_edge && owed_reg != '0 && fifo_out_valid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            owed_reg <= '0;
        end else if (ce) begin
            owed_reg <= owed_reg + (rd_cmd ? BURST_CNT : '0)
                        - (launch ? `DCS_OWED_W'(1) : '0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lstate_reg <= dcs_pkg::DCS_L_IDLE;
            exp_n_reg  <= 1'b0;
        end else if (ce) begin
            case (lstate_reg)
                dcs_pkg::DCS_L_IDLE: begin
                    if (rd_cmd) begin
                        lstate_reg <= dcs_pkg::DCS_L_WAIT_KN;
                    end
                end
                dcs_pkg::DCS_L_WAIT_KN: begin
                    if (launch) begin
                        lstate_reg <= dcs_pkg::DCS_L_STREAM;
                        exp_n_reg  <= 1'b0;
                    end else if (kn_rise) begin
                        lstate_reg <= single_reg ?
                                      dcs_pkg::DCS_L_WAIT_KN :
                                      dcs_pkg::DCS_L_WAIT_CN;
                    end
                end
                dcs_pkg::DCS_L_WAIT_CN: begin
                    if (launch) begin
                        lstate_reg <= dcs_pkg::DCS_L_STREAM;
                        exp_n_reg  <= 1'b0;
                    end
                end
                dcs_pkg::DCS_L_STREAM: begin
                    if (launch) begin
                        exp_n_reg <= !exp_n_reg;
                    end else if (k_rise && owed_reg == '0) begin
                        lstate_reg <= rd_cmd ?
                                      dcs_pkg::DCS_L_WAIT_KN :
                                      dcs_pkg::DCS_L_IDLE;
                    end
                end
                default: begin
                    lstate_reg <= dcs_pkg::DCS_L_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_io_out <= '0;
            data_io_oe  <= 1'b0;
        end else if (ce) begin
            if (launch) begin
                data_io_out <= fifo_out_data;
                data_io_oe  <= 1'b1;
            end else if (lstate_reg == dcs_pkg::DCS_L_STREAM && k_rise
                         && owed_reg == '0) begin
                data_io_oe <= 1'b0;
            end
        end
    end

    // Echo clocks follow whichever pair times the output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            echo_pair <= 2'h0;
        end else if (ce) begin
            echo_pair <= single_reg ? {k_s, kn_s} : {c_s, cn_s};
        end
    end
endmodule // dcs_sram_port
